// File: rtl/adc_serial_map.svh
// timing, pin and reset constants for the serial result readout port
// Behaviour
// - clock select low: device drives clock, frame
// - master clock and frame polarity invertible
// - read timing pin picks after or during
// - master read-after keeps busy until shifted
// - master read-during shifts in first half only
// - clock select high: host clock shifts data
// - host clock counts only when selected
// - any host clock shape, idle high or low
// - slave read-after sends result MSB first
// - host clock rate up to the maximum
// - slave mode takes chain bits from pin
// - chain bit latched on opposite clock edge
// - slave read-during sends previous result
// - partial read at conversion end pulses error
// - serial port active when port select high
// - select and read ORed, high disables data and clock outputs
// - started conversion always runs to completion
`ifndef ADC_SERIAL_MAP_SVH
`define ADC_SERIAL_MAP_SVH
`define RESULT_BITS 16
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 7000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MSCLK_HALF_NS 100
`define MSCLK_HALF_CYCLES ((`MSCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 16
`define PIN_CNV 0
`define PIN_CS 1
`define PIN_RD 2
`define PIN_SCLK 3
`define PIN_CHAIN 4
`define PIN_CLKSEL 5
`define PIN_PORTSEL 6
`define PIN_INVERT 7
`define PIN_COUNT 8
`define SCLK_IDLE 1'b0
`define PIN_RESET 8'hff
`endif

// File: rtl/adc_serial_pkg.sv
// types of the serial result readout port
package adc_serial_pkg;
   typedef enum logic [2:0] {
      CONV_IDLE = 3'b001,
      CONV_RUN = 3'b010,
      CONV_DRAIN = 3'b100
   } conv_state_type;

   typedef struct packed {
      conv_state_type state;
      logic [15:0] convCnt;
      logic [7:0] s1;
      logic [7:0] s2;
      logic prevSclk;
      logic prevCnv;
      logic [15:0] shiftReg;
      logic [4:0] bitCnt;
      logic chainBit;
      logic [15:0] divCnt;
      logic sclkLevel;
      logic serialOut;
      logic serialOe;
      logic sclkOut;
      logic sclkOe;
      logic syncOut;
      logic busy;
      logic overrun;
   } port_state_type;
endpackage : adc_serial_pkg

// File: rtl/result_fifo.sv
// result word fifo with valid and ready on both sides
`timescale 1ns/100ps
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } fifo_state_type;

   fifo_state_type r_r;
   fifo_state_type r_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] used;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
         $error("fifo depth must be a power of two, width positive");
      end
   endgenerate

   assign used = r_r.wrPtr - r_r.rdPtr;
   assign inReady = (used != FULL);
   assign outValid = (used != '0);
   assign outData = mem[r_r.rdPtr[AW-1:0]];

   always_comb begin
      r_nxt = r_r;
      if (inValid && inReady) begin
         r_nxt.wrPtr = r_r.wrPtr + (AW+1)'(1);
      end
      if (outValid && outReady) begin
         r_nxt.rdPtr = r_r.rdPtr + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
      if (inValid && inReady) begin
         mem[r_r.wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule : result_fifo

// File: rtl/adc_serial_readout_port.sv
// serial result readout port: conversion timing, master and slave shifter
`timescale 1ns/100ps
`include "adc_serial_map.svh"
module adc_serial_readout_port #(
   parameter int CONV_CYCLES = `CONV_CYCLES,
   parameter int MASTER_HALF = `MSCLK_HALF_CYCLES,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic convertStartN,
   input wire logic chipSelectN,
   input wire logic readN,
   input wire logic sclkIn,
   input wire logic readTimingOrChainIn,
   input wire logic clockSourceSelect,
   input wire logic portTypeSelect,
   input wire logic invertMasterClock,
   input wire logic [15:0] resultIn,
   output logic serialResultOut,
   output logic serialResultOe,
   output logic sclkOut,
   output logic sclkOe,
   output logic frameSyncOut,
   output logic busy,
   output logic readOverrunPulse
);
   // ----------------------------------------------------------------
   // constants and checks
   // ----------------------------------------------------------------
   localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
   localparam logic [15:0] CONV_HALF = 16'(CONV_CYCLES / 2);
   localparam logic [15:0] HALF_LAST = 16'(MASTER_HALF - 1);
   localparam logic [4:0] BITS = 5'(`RESULT_BITS);

   generate
      if (CONV_CYCLES < 2 || CONV_CYCLES > 65535 || MASTER_HALF < 1 ||
          MASTER_HALF > 65535 || 4 * `RESULT_BITS * MASTER_HALF > CONV_CYCLES) begin : g_bad
         $error("conversion or master clock count out of range");
      end
   endgenerate

   // ----------------------------------------------------------------
   // state and result fifo
   // ----------------------------------------------------------------
   adc_serial_pkg::port_state_type r_r;
   adc_serial_pkg::port_state_type r_nxt;
   logic [`PIN_COUNT-1:0] pinsRaw;
   logic fifoInReady;
   logic fifoOutValid;
   logic [15:0] fifoOutData;
   logic pushValid;
   logic popReady;
   logic isMaster;
   logic readAfter;
   logic selected;
   logic portOn;
   logic invert;
   logic cnvFall;
   logic sclkRise;
   logic sclkFall;
   logic convEnd;
   logic masterGate;
   logic shiftNow;
   logic latchNow;

   assign pinsRaw = {invertMasterClock, portTypeSelect, clockSourceSelect,
                     readTimingOrChainIn, sclkIn, readN, chipSelectN, convertStartN};

   result_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .inValid(pushValid),
      .inReady(fifoInReady),
      .inData(resultIn),
      .outValid(fifoOutValid),
      .outReady(popReady),
      .outData(fifoOutData)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      r_nxt = r_r;
      r_nxt.s1 = pinsRaw;
      r_nxt.s2 = r_r.s1;
      r_nxt.prevSclk = r_r.s2[`PIN_SCLK];
      r_nxt.prevCnv = r_r.s2[`PIN_CNV];
      r_nxt.overrun = 1'b0;
      popReady = 1'b0;
      shiftNow = 1'b0;
      latchNow = 1'b0;

      isMaster = ~r_r.s2[`PIN_CLKSEL];
      readAfter = r_r.s2[`PIN_CHAIN];
      selected = ~(r_r.s2[`PIN_CS] | r_r.s2[`PIN_RD]);
      portOn = r_r.s2[`PIN_PORTSEL];
      invert = r_r.s2[`PIN_INVERT];
      cnvFall = r_r.prevCnv & ~r_r.s2[`PIN_CNV];
      sclkRise = ~r_r.prevSclk & r_r.s2[`PIN_SCLK];
      sclkFall = r_r.prevSclk & ~r_r.s2[`PIN_SCLK];
      convEnd = (r_r.state == adc_serial_pkg::CONV_RUN) && (r_r.convCnt == CONV_LAST);
      pushValid = convEnd;

      // conversion sequencing; a start during a conversion is ignored
      case (r_r.state)
         adc_serial_pkg::CONV_IDLE: begin
            if (cnvFall && fifoInReady) begin
               r_nxt.state = adc_serial_pkg::CONV_RUN;
               r_nxt.convCnt = '0;
            end
         end
         adc_serial_pkg::CONV_RUN: begin
            if (convEnd) begin
               if (isMaster && readAfter) begin
                  r_nxt.state = adc_serial_pkg::CONV_DRAIN;
               end else begin
                  r_nxt.state = adc_serial_pkg::CONV_IDLE;
               end
            end else begin
               r_nxt.convCnt = r_r.convCnt + 16'h0001;
            end
         end
         adc_serial_pkg::CONV_DRAIN: begin
            if (r_r.bitCnt == BITS && !fifoOutValid) begin
               r_nxt.state = adc_serial_pkg::CONV_IDLE;
            end
         end
         default: begin
            r_nxt.state = adc_serial_pkg::CONV_IDLE;
         end
      endcase

      // master clock only in drain or the first half of a conversion
      if (readAfter) begin
         masterGate = isMaster && (r_r.state == adc_serial_pkg::CONV_DRAIN);
      end else begin
         masterGate = isMaster && (r_r.state == adc_serial_pkg::CONV_RUN) &&
                      (r_r.convCnt < CONV_HALF);
      end

      if (masterGate && r_r.bitCnt < BITS) begin
         if (r_r.divCnt == HALF_LAST) begin
            r_nxt.divCnt = '0;
            r_nxt.sclkLevel = ~r_r.sclkLevel;
            shiftNow = r_r.sclkLevel;
         end else begin
            r_nxt.divCnt = r_r.divCnt + 16'h0001;
         end
      end else begin
         r_nxt.divCnt = '0;
         r_nxt.sclkLevel = `SCLK_IDLE;
      end

      if (!isMaster && selected) begin
         shiftNow = sclkFall;
         latchNow = sclkRise;
      end

      if (latchNow) begin
         r_nxt.chainBit = r_r.s2[`PIN_CHAIN];
      end
      if (shiftNow) begin
         r_nxt.shiftReg = {r_r.shiftReg[14:0], isMaster ? 1'b0 : r_r.chainBit};
         if (r_r.bitCnt < BITS) begin
            r_nxt.bitCnt = r_r.bitCnt + 5'h01;
         end
      end

      // an unfinished word is dropped when the next result lands
      if (convEnd && r_r.bitCnt != BITS) begin
         r_nxt.bitCnt = BITS;
         r_nxt.overrun = (r_r.bitCnt != 5'h00);
      end

      if (fifoOutValid && r_r.bitCnt == BITS && !shiftNow && !convEnd) begin
         popReady = 1'b1;
         r_nxt.shiftReg = fifoOutData;
         r_nxt.bitCnt = 5'h00;
      end

      // registered pin drive
      r_nxt.busy = (r_nxt.state != adc_serial_pkg::CONV_IDLE);
      r_nxt.serialOut = r_nxt.shiftReg[15];
      r_nxt.serialOe = portOn && selected;
      r_nxt.sclkOe = portOn && selected && isMaster;
      r_nxt.sclkOut = isMaster ? (r_nxt.sclkLevel ^ invert) : 1'b0;
      r_nxt.syncOut = isMaster ? ((masterGate && r_nxt.bitCnt < BITS) ^ invert) : 1'b0;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         r_r <= '0;
         r_r.state <= adc_serial_pkg::CONV_IDLE;
         r_r.s1 <= `PIN_RESET;
         r_r.s2 <= `PIN_RESET;
         r_r.prevSclk <= `SCLK_IDLE;
         r_r.prevCnv <= 1'b1;
         r_r.bitCnt <= BITS;
         r_r.sclkLevel <= `SCLK_IDLE;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign serialResultOut = r_r.serialOut;
   assign serialResultOe = r_r.serialOe;
   assign sclkOut = r_r.sclkOut;
   assign sclkOe = r_r.sclkOe;
   assign frameSyncOut = r_r.syncOut;
   assign busy = r_r.busy;
   assign readOverrunPulse = r_r.overrun;
endmodule : adc_serial_readout_port

// File: dv/adc_serial_readout_port_chk.sv
// pin-level assertions for the serial result readout port
`timescale 1ns/100ps
module adc_serial_readout_port_chk #(
   parameter int CONV_CYCLES = 140,
   parameter int MASTER_HALF = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic convertStartN,
   input wire logic chipSelectN,
   input wire logic readN,
   input wire logic sclkIn,
   input wire logic readTimingOrChainIn,
   input wire logic clockSourceSelect,
   input wire logic portTypeSelect,
   input wire logic invertMasterClock,
   input wire logic [15:0] resultIn,
   input wire logic serialResultOut,
   input wire logic serialResultOe,
   input wire logic sclkOut,
   input wire logic sclkOe,
   input wire logic frameSyncOut,
   input wire logic busy,
   input wire logic readOverrunPulse
);
   // ---------------------------------------------
   // busy length and time since reset
   // ---------------------------------------------
   int busyCnt;
   logic [3:0] upCnt;
   always_ff @(posedge clk) begin
      busyCnt <= (rst || !busy) ? 0 : busyCnt + 1;
      upCnt <= rst ? 4'h0 : (upCnt == 4'hf ? upCnt : upCnt + 4'h1);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_busy_width: assert property (
      $fell(busy) && (clockSourceSelect || !readTimingOrChainIn)
      |-> busyCnt inside {[CONV_CYCLES-1:CONV_CYCLES+1]}) else $error("busy width off");
   a_busy_extend: assert property (
      $fell(busy) && !clockSourceSelect && readTimingOrChainIn
      |-> busyCnt >= CONV_CYCLES + 30 * MASTER_HALF) else $error("busy not extended");
   a_quiet_half: assert property (
      !clockSourceSelect && !readTimingOrChainIn && busyCnt > CONV_CYCLES / 2 + 4
      |-> $stable(sclkOut)) else $error("late clock");
   a_slave_quiet: assert property (
      clockSourceSelect [*5] |-> !sclkOe && !sclkOut) else $error("slave drives clock");
   a_deselect_hiz: assert property (
      (chipSelectN || readN) [*5] |-> !serialResultOe && !sclkOe)
      else $error("driving while deselected");
   a_port_off: assert property (
      !portTypeSelect [*5] |-> !serialResultOe && !sclkOe) else $error("driving while port off");
   a_overrun_once: assert property (
      readOverrunPulse |=> !readOverrunPulse) else $error("overrun too long");
   a_overrun_end: assert property (
      readOverrunPulse |-> ##[0:3] !busy) else $error("overrun off conversion end");
   a_frame_gate: assert property (
      upCnt == 4'hf && $changed(sclkOut) && !clockSourceSelect && $stable(invertMasterClock)
      |-> (frameSyncOut ^ invertMasterClock)
      || ($past(frameSyncOut) ^ $past(invertMasterClock))) else $error("clock outside frame");
   c_slave_end: cover property ($fell(busy) && clockSourceSelect);
   c_overrun: cover property (readOverrunPulse);
   c_frame: cover property ($rose(frameSyncOut ^ invertMasterClock));
endmodule : adc_serial_readout_port_chk
bind adc_serial_readout_port adc_serial_readout_port_chk #(
   .CONV_CYCLES(CONV_CYCLES),
   .MASTER_HALF(MASTER_HALF)
) i_adc_serial_readout_port_chk (
   .clk(clk),
   .rst(rst),
   .convertStartN(convertStartN),
   .chipSelectN(chipSelectN),
   .readN(readN),
   .sclkIn(sclkIn),
   .readTimingOrChainIn(readTimingOrChainIn),
   .clockSourceSelect(clockSourceSelect),
   .portTypeSelect(portTypeSelect),
   .invertMasterClock(invertMasterClock),
   .resultIn(resultIn),
   .serialResultOut(serialResultOut),
   .serialResultOe(serialResultOe),
   .sclkOut(sclkOut),
   .sclkOe(sclkOe),
   .frameSyncOut(frameSyncOut),
   .busy(busy),
   .readOverrunPulse(readOverrunPulse)
);

// File: dv/host_serial_model.sv
// host serial port model: slave clocking, selection, master capture
`timescale 1ns/100ps
module host_serial_model (
   input wire logic clk,
   input wire logic serialResultOut,
   input wire logic serialResultOe,
   input wire logic sclkOut,
   input wire logic sclkOe,
   input wire logic frameSyncOut,
   input wire logic invertMasterClock,
   output logic sclkIn = 1'h0,
   output logic chipSelectN = 1'h1,
   output logic readN = 1'h1,
   output logic readTimingOrChainIn = 1'h0
);
   // ---------------------------------------------
   // released data pin shows the inverse of its last value
   // ---------------------------------------------
   logic lastBit = 1'h0;
   logic prevClk = 1'h1;
   logic [15:0] mWord = 16'h0;
   int mCnt = 0;
   wire pin = serialResultOe ? serialResultOut : ~lastBit;
   always @(posedge clk) begin
      if (serialResultOe) lastBit <= serialResultOut;
      prevClk <= sclkOe ? sclkOut ^ invertMasterClock : 1'h1;
      if (sclkOe && (sclkOut ^ invertMasterClock) && !prevClk &&
          (frameSyncOut ^ invertMasterClock)) begin
         mWord <= {mWord[14:0], pin};
         mCnt <= mCnt + 1;
      end
   end
   task sel(input logic v);
      @(posedge clk);
      chipSelectN <= v;
      readN <= v;
      repeat (4) @(posedge clk);
   endtask : sel
   task tick(input logic v, input logic c);
      @(posedge clk);
      sclkIn <= v;
      readTimingOrChainIn <= c;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : tick
   // each bit is taken just before the falling clock edge
   task readBits(input int n, input logic idle, input logic fix, input logic [15:0] up,
      output logic [31:0] got);
      got = 32'h0;
      tick(idle, fix ? readTimingOrChainIn : up[15]);
      sel(1'h0);
      for (int i = 0; i < n; i++) begin
         if (!idle) tick(1'h1, readTimingOrChainIn);
         got = {got[30:0], pin};
         tick(1'h0, fix ? readTimingOrChainIn : up[15 - (i + 1) % 16]);
         if (idle) tick(1'h1, readTimingOrChainIn);
      end
      sel(1'h1);
   endtask : readBits
endmodule : host_serial_model

// File: dv/tb.sv
// self-checking bench for the serial result readout port
`timescale 1ns/100ps
module tb;
   logic clk = 1'h0, rst = 1'h1, convertStartN = 1'h1, clockSourceSelect = 1'h1;
   logic portTypeSelect = 1'h1, invertMasterClock = 1'h0;
   logic [15:0] resultIn = 16'h0;
   logic chipSelectN, readN, sclkIn, readTimingOrChainIn, serialResultOut, serialResultOe;
   logic sclkOut, sclkOe, frameSyncOut, busy, readOverrunPulse;
   logic [31:0] got;
   int n_mismatch = 0, num_checks = 0, nOver = 0;
   adc_serial_readout_port #(
      .CONV_CYCLES(300),
      .MASTER_HALF(2)
   ) i_adc_serial_readout_port (
      .clk(clk),
      .rst(rst),
      .convertStartN(convertStartN),
      .chipSelectN(chipSelectN),
      .readN(readN),
      .sclkIn(sclkIn),
      .readTimingOrChainIn(readTimingOrChainIn),
      .clockSourceSelect(clockSourceSelect),
      .portTypeSelect(portTypeSelect),
      .invertMasterClock(invertMasterClock),
      .resultIn(resultIn),
      .serialResultOut(serialResultOut),
      .serialResultOe(serialResultOe),
      .sclkOut(sclkOut),
      .sclkOe(sclkOe),
      .frameSyncOut(frameSyncOut),
      .busy(busy),
      .readOverrunPulse(readOverrunPulse)
   );
   host_serial_model i_host_serial_model (
      .clk(clk),
      .serialResultOut(serialResultOut),
      .serialResultOe(serialResultOe),
      .sclkOut(sclkOut),
      .sclkOe(sclkOe),
      .frameSyncOut(frameSyncOut),
      .invertMasterClock(invertMasterClock),
      .sclkIn(sclkIn),
      .chipSelectN(chipSelectN),
      .readN(readN),
      .readTimingOrChainIn(readTimingOrChainIn)
   );
   // ---------------------------------------------
   // clock, overrun count, watchdog, tasks
   // ---------------------------------------------
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (readOverrunPulse === 1'h1) nOver++;
   initial begin
      #(50 * 60000);
      n_mismatch++;
      results();
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   task restart(input logic s, input logic p, input logic inv);
      @(posedge clk);
      rst <= 1'h1;
      clockSourceSelect <= s;
      i_host_serial_model.readTimingOrChainIn <= p;
      @(posedge clk);
      invertMasterClock <= inv;
      repeat (15) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
   endtask : restart
   task pulse();
      @(posedge clk);
      convertStartN <= 1'h0;
      repeat (3) @(posedge clk);
      convertStartN <= 1'h1;
   endtask : pulse
   task conv(input logic [15:0] r);
      @(posedge clk);
      resultIn <= r;
      pulse();
      for (int k = 0; k < 20 && busy !== 1'h1; k++) @(negedge clk);
      chk(busy, 1, "busy rise");
   endtask : conv
   task waitIdle();
      for (int k = 0; k < 2000 && busy !== 1'h0; k++) @(negedge clk);
      chk(busy, 0, "busy fall");
      repeat (4) @(posedge clk);
   endtask : waitIdle
   initial begin
      restart(1'h1, 1'h0, 1'h0);
      conv(16'ha5c3);
      waitIdle();
      i_host_serial_model.readBits(32, 1'h0, 1'h0, 16'h3c5a, got);
      chk(got, 32'ha5c33c5a, "chain read");
      $display("test slave after done");
      restart(1'h1, 1'h0, 1'h0);
      conv(16'h8001);
      waitIdle();
      i_host_serial_model.readBits(16, 1'h1, 1'h1, 16'h0, got);
      chk(got, 32'h8001, "idle high read");
      $display("test idle high done");
      restart(1'h1, 1'h1, 1'h0);
      conv(16'h1234);
      waitIdle();
      conv(16'h5678);
      pulse();
      i_host_serial_model.readBits(16, 1'h0, 1'h1, 16'h0, got);
      chk(got, 32'h1234, "read during");
      waitIdle();
      conv(16'h9abc);
      i_host_serial_model.readBits(5, 1'h0, 1'h1, 16'h0, got);
      chk(got, 32'h0000000a, "partial read");
      waitIdle();
      chk(nOver, 1, "overrun count");
      $display("test slave during done");
      restart(1'h0, 1'h1, 1'h0);
      i_host_serial_model.sel(1'h0);
      portTypeSelect <= 1'h0;
      repeat (8) @(negedge clk);
      chk(sclkOe, 0, "port off");
      @(posedge clk);
      portTypeSelect <= 1'h1;
      repeat (8) @(negedge clk);
      chk(sclkOe, 1, "master clock drive");
      conv(16'hc3a5);
      waitIdle();
      chk(i_host_serial_model.mWord, 16'hc3a5, "master after word");
      chk(i_host_serial_model.mCnt, 16, "master after bits");
      $display("test master after done");
      restart(1'h0, 1'h0, 1'h1);
      conv(16'h0ff0);
      waitIdle();
      conv(16'h7e81);
      waitIdle();
      chk(i_host_serial_model.mWord, 16'h0ff0, "master during word");
      chk(i_host_serial_model.mCnt, 32, "master during bits");
      $display("test master during done");
      results();
   end
endmodule : tb
